/* File: e1ri_regs.svh */
// e1ri_regs.svh: offsets-free constant set for the e1 channel reset/init block:
// field positions, reset values and timing figures.
// assumes a 40 MHz mclk; included by bare name wherever needed.
`ifndef E1RI_REGS_SVH
`define E1RI_REGS_SVH

// reset values of the configuration bytes
`define E1RI_FMR_RST 8'h00
`define E1RI_SPARE_RST 8'h00
`define E1RI_SIC_RST 8'h00
`define E1RI_GLOB_RST 8'h00
`define E1RI_MODE_RST 8'h00
`define E1RI_IMR_RST 8'hFF
`define E1RI_ADDR_HI_RST 8'hFD
`define E1RI_ADDR_RST 8'hFF
`define E1RI_LOS_DET_RST 8'h00
`define E1RI_LOS_REC_RST 8'h00

// field positions
`define E1RI_PROT_SEL_BIT 0
`define E1RI_AUTO_RSY_BIT 1
`define E1RI_AUTO_RA_BIT 4
`define E1RI_AUTO_MF_BIT 5
`define E1RI_FRM_SEL_LO 6
`define E1RI_FRM_SEL_HI 7
`define E1RI_EXT_IW_BIT 0
`define E1RI_EBIT_LO 0
`define E1RI_EBIT_HI 1
`define E1RI_AUTO_EB_BIT 3
`define E1RI_EB_POL_BIT 4
`define E1RI_XMIT_RST_BIT 4
`define E1RI_RECV_RST_BIT 6

// framing select codes
`define E1RI_RFS_CRC4 2'b10
`define E1RI_RFS_IWORK 2'b11

// timing figures
`define E1RI_CLK_KHZ 40000
`define E1RI_CLK_MHZ 40
`define E1RI_RESET_MIN_US 10
`define E1RI_RESET_MIN_CYC (`E1RI_RESET_MIN_US * `E1RI_CLK_MHZ)
`define E1RI_RESYNC_MS 8
`define E1RI_IWORK_MS 400
`define E1RI_SECOND_MS 1000
`define E1RI_CRC_ERR_LIMIT 914
`define E1RI_LOS_BLOCK 16

`endif

/* File: e1ri_pkg.sv */
// e1ri_pkg.sv: types shared by the e1 channel reset/init block.
// assumes nothing beyond a systemverilog compiler.
package e1ri_pkg;

  typedef enum logic [1:0] {
    E1RI_ST_DOUBLE = 2'b00,
    E1RI_ST_MF_SEARCH = 2'b01,
    E1RI_ST_MF_SYNC = 2'b10,
    E1RI_ST_IW_HOLD = 2'b11
  } e1ri_sync_t;

  typedef logic [7:0] e1ri_byte_t;

endpackage

/* File: e1ri_los_det.sv */
// e1ri_los_det.sv: loss-of-signal detector on the received line bits.
// assumes rx_bit is valid when bit_en pulses, one pulse per line bit.
`timescale 1ns/10ps
`include "e1ri_regs.svh"

module e1ri_los_det (
  input wire logic mclk,
  input wire logic rst,
  input wire logic bit_en,
  input wire logic rx_bit,
  input wire logic [7:0] los_detect_count,
  input wire logic [7:0] los_recovery_count,
  output logic los_ff
);

  logic [12:0] zero_cnt_ff;
  logic [12:0] nxt_zero_cnt;
  logic [12:0] win_cnt_ff;
  logic [12:0] nxt_win_cnt;
  logic [8:0] ones_cnt_ff;
  logic [8:0] nxt_ones_cnt;
  logic nxt_los;
  logic [12:0] interval;

  // interval in bits is (count + 1) blocks of 16
  assign interval = 13'(({5'h0, los_detect_count} + 13'h0001) * 13'(`E1RI_LOS_BLOCK));

  always_comb begin
    nxt_zero_cnt = zero_cnt_ff;
    nxt_win_cnt = win_cnt_ff;
    nxt_ones_cnt = ones_cnt_ff;
    nxt_los = los_ff;
    if (bit_en) begin
      if (rx_bit) begin
        nxt_zero_cnt = 13'h0000;
      end else if (zero_cnt_ff != 13'h1FFF) begin
        nxt_zero_cnt = zero_cnt_ff + 13'h0001;
      end
      if (!los_ff && nxt_zero_cnt >= interval) begin
        nxt_los = 1'b1;
        nxt_win_cnt = 13'h0000;
        nxt_ones_cnt = 9'h000;
      end else if (los_ff) begin
        // recovery: enough ones inside one detection interval
        nxt_ones_cnt = ones_cnt_ff + {8'h00, rx_bit};
        nxt_win_cnt = win_cnt_ff + 13'h0001;
        if (nxt_ones_cnt >= {1'b0, los_recovery_count} + 9'h001) begin
          nxt_los = 1'b0;
          nxt_zero_cnt = 13'h0000;
        end else if (nxt_win_cnt >= interval) begin
          nxt_win_cnt = 13'h0000;
          nxt_ones_cnt = 9'h000;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      zero_cnt_ff <= 13'h0000;
      win_cnt_ff <= 13'h0000;
      ones_cnt_ff <= 9'h000;
      los_ff <= 1'b0;
    end else begin
      zero_cnt_ff <= nxt_zero_cnt;
      win_cnt_ff <= nxt_win_cnt;
      ones_cnt_ff <= nxt_ones_cnt;
      los_ff <= nxt_los;
    end
  end

endmodule

/* File: e1ri_channel.sv */
// e1ri_channel.sv: reset, default configuration and automatic framer actions
// for one e1 channel. configuration bytes are loaded through per-register strobes
// sharing one data byte; framer events come in as one-cycle pulses.
// assumes every input is synchronous to mclk (40 MHz).
`timescale 1ns/10ps
`include "e1ri_regs.svh"

// Operation
// - reset input high for at least 10 us puts the block in reset
// - during reset outputs are released and registers take defaults
// - after reset the receiver runs in doubleframe format
// - framer mode bytes reset to zero
// - system interface control bytes reset to zero
// - all interrupt mask bytes reset to all ones
// - global configuration resets to zero: internal timer, all channels on
// - mode resets to zero; address compares reset to FD, FF, FF, FF (block keeps only two: high FD, low FF)
// - unused addresses read undefined; host avoids writing them
// - status continuously updated; command byte is write-only
// - detect count 0x0A gives loss of signal after 176 zeros
// - recovery count 0x15 clears loss of signal after 22 ones
// - auto e-bit sends received submultiframe crc errors next multiframe
// - while unframed each sent e-bit equals the polarity control
// - auto remote alarm follows loss of frame alignment
// - crc4 mode with auto resync restarts doubleframe search after 8 ms
// - more than 914 crc4 errors in a second restarts alignment search
// - interworking: 400 ms timeout interrupt; extended mode also raises alarm and keeps searching
// - receiver reset clears receive side but keeps control bytes
module e1ri_channel #(
  parameter int unsigned RESYNC_CYC = `E1RI_RESYNC_MS * `E1RI_CLK_KHZ,
  parameter int unsigned IWORK_CYC = `E1RI_IWORK_MS * `E1RI_CLK_KHZ,
  parameter int unsigned SECOND_CYC = `E1RI_SECOND_MS * `E1RI_CLK_KHZ
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] cfg_data,
  input wire logic load_framer_mode_0,
  input wire logic load_framer_mode_1,
  input wire logic load_framer_mode_2,
  input wire logic load_framer_mode_3,
  input wire logic load_xmit_spare,
  input wire logic load_system_interface_control,
  input wire logic load_global_configuration,
  input wire logic load_mode,
  input wire logic load_interrupt_mask_regs,
  input wire logic load_los_detect_count,
  input wire logic load_los_recovery_count,
  input wire logic write_command_register,
  input wire logic rx_bit_en,
  input wire logic rx_bit,
  input wire logic loss_of_frame_flag,
  input wire logic mf_found,
  input wire logic mf_start,
  input wire logic smf1_crc_err,
  input wire logic smf2_crc_err,
  input wire logic crc4_err,
  output logic out_enable_ff,
  output logic [7:0] framer_mode_0_ff,
  output logic [7:0] framer_mode_1_ff,
  output logic [7:0] framer_mode_2_ff,
  output logic [7:0] framer_mode_3_ff,
  output logic [7:0] xmit_spare_ff,
  output logic [7:0] system_interface_control_ff,
  output logic [7:0] global_configuration_ff,
  output logic [7:0] mode_ff,
  output logic [7:0] interrupt_mask_regs_ff,
  output logic [7:0] receive_addr_high_compare_ff,
  output logic [7:0] receive_addr_low_compare_ff,
  output logic [7:0] los_detect_count_ff,
  output logic [7:0] los_recovery_count_ff,
  output logic los_ff,
  output logic [1:0] sync_state_ff,
  output logic [1:0] ebit_tx_ff,
  output logic rai_tx_ff,
  output logic restart_search_ff,
  output logic iw_timeout_irq_ff,
  output logic transmitter_reset_ff,
  output logic receiver_reset_ff
);

  // reset release pipeline: first stage feeds only the second
  logic rst_meta_ff;
  logic rst_hold_ff;
  logic rst;
  logic rx_rst;

  always_ff @(posedge mclk) begin
    rst_meta_ff <= reset;
    rst_hold_ff <= rst_meta_ff;
  end

  // internal reset asserts at once and drops two edges after the input
  assign rst = reset | rst_hold_ff;
  assign rx_rst = rst | receiver_reset_ff;

  // configuration bytes
  e1ri_pkg::e1ri_byte_t nxt_fm0, nxt_fm1, nxt_fm2, nxt_fm3, nxt_spare;
  e1ri_pkg::e1ri_byte_t nxt_sic, nxt_glob, nxt_mode, nxt_imr, nxt_los_det, nxt_los_rec;
  logic nxt_xmit_rst;
  logic nxt_recv_rst;

  // only named bytes have strobes, so an unused place can never be written
  always_comb begin
    nxt_fm0 = load_framer_mode_0 ? cfg_data : framer_mode_0_ff;
    nxt_fm1 = load_framer_mode_1 ? cfg_data : framer_mode_1_ff;
    nxt_fm2 = load_framer_mode_2 ? cfg_data : framer_mode_2_ff;
    nxt_fm3 = load_framer_mode_3 ? cfg_data : framer_mode_3_ff;
    nxt_spare = load_xmit_spare ? cfg_data : xmit_spare_ff;
    nxt_sic = load_system_interface_control ? cfg_data : system_interface_control_ff;
    nxt_glob = load_global_configuration ? cfg_data : global_configuration_ff;
    nxt_mode = load_mode ? cfg_data : mode_ff;
    nxt_imr = load_interrupt_mask_regs ? cfg_data : interrupt_mask_regs_ff;
    nxt_los_det = load_los_detect_count ? cfg_data : los_detect_count_ff;
    nxt_los_rec = load_los_recovery_count ? cfg_data : los_recovery_count_ff;
    // command byte is not stored: its reset bits 4 and 6 become one-cycle pulses, the rest are ignored
    nxt_xmit_rst = write_command_register & cfg_data[`E1RI_XMIT_RST_BIT];
    nxt_recv_rst = write_command_register & cfg_data[`E1RI_RECV_RST_BIT];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      out_enable_ff <= 1'b0;
      framer_mode_0_ff <= `E1RI_FMR_RST;
      framer_mode_1_ff <= `E1RI_FMR_RST;
      framer_mode_2_ff <= `E1RI_FMR_RST;
      framer_mode_3_ff <= `E1RI_FMR_RST;
      xmit_spare_ff <= `E1RI_SPARE_RST;
      system_interface_control_ff <= `E1RI_SIC_RST;
      global_configuration_ff <= `E1RI_GLOB_RST;
      mode_ff <= `E1RI_MODE_RST;
      interrupt_mask_regs_ff <= `E1RI_IMR_RST;
      receive_addr_high_compare_ff <= `E1RI_ADDR_HI_RST;
      receive_addr_low_compare_ff <= `E1RI_ADDR_RST;
      los_detect_count_ff <= `E1RI_LOS_DET_RST;
      los_recovery_count_ff <= `E1RI_LOS_REC_RST;
      transmitter_reset_ff <= 1'b0;
      receiver_reset_ff <= 1'b0;
    end else begin
      out_enable_ff <= 1'b1;
      framer_mode_0_ff <= nxt_fm0;
      framer_mode_1_ff <= nxt_fm1;
      framer_mode_2_ff <= nxt_fm2;
      framer_mode_3_ff <= nxt_fm3;
      xmit_spare_ff <= nxt_spare;
      system_interface_control_ff <= nxt_sic;
      global_configuration_ff <= nxt_glob;
      mode_ff <= nxt_mode;
      interrupt_mask_regs_ff <= nxt_imr;
      receive_addr_high_compare_ff <= receive_addr_high_compare_ff;
      receive_addr_low_compare_ff <= receive_addr_low_compare_ff;
      los_detect_count_ff <= nxt_los_det;
      los_recovery_count_ff <= nxt_los_rec;
      transmitter_reset_ff <= nxt_xmit_rst;
      receiver_reset_ff <= nxt_recv_rst;
    end
  end

  // decoded control bits
  logic auto_remote_alarm;
  logic auto_multiframe_resync;
  logic auto_resync_enable;
  logic extended_interworking;
  logic [1:0] receive_framing_select;
  logic auto_ebit_send;
  logic ebit_polarity_control;

  assign auto_remote_alarm = framer_mode_2_ff[`E1RI_AUTO_RA_BIT];
  assign auto_multiframe_resync = framer_mode_2_ff[`E1RI_AUTO_MF_BIT];
  assign receive_framing_select = framer_mode_2_ff[`E1RI_FRM_SEL_HI:`E1RI_FRM_SEL_LO];
  assign auto_resync_enable = framer_mode_1_ff[`E1RI_AUTO_RSY_BIT];
  assign extended_interworking = framer_mode_3_ff[`E1RI_EXT_IW_BIT];
  assign auto_ebit_send = xmit_spare_ff[`E1RI_AUTO_EB_BIT];
  assign ebit_polarity_control = xmit_spare_ff[`E1RI_EB_POL_BIT];

  e1ri_los_det u_los (
    .mclk(mclk),
    .rst(rx_rst),
    .bit_en(rx_bit_en),
    .rx_bit(rx_bit),
    .los_detect_count(los_detect_count_ff),
    .los_recovery_count(los_recovery_count_ff),
    .los_ff(los_ff)
  );

  // multiframe alignment sequencing
  e1ri_pkg::e1ri_sync_t st_ff, nxt_st;
  logic [25:0] tmr_ff, nxt_tmr;
  logic [25:0] sec_ff, nxt_sec;
  logic [9:0] crc_cnt_ff, nxt_crc_cnt;
  logic iw_rai_ff, nxt_iw_rai;
  logic nxt_restart;
  logic nxt_iw_irq;
  logic sec_tick;

  // one-second timer is always internal; the global configuration byte is not decoded
  assign sec_tick = (sec_ff == 26'(SECOND_CYC - 1));

  always_comb begin
    nxt_st = st_ff;
    nxt_tmr = tmr_ff;
    nxt_sec = sec_tick ? 26'h000_0000 : sec_ff + 26'h000_0001;
    nxt_crc_cnt = sec_tick ? 10'h000 : crc_cnt_ff;
    nxt_iw_rai = iw_rai_ff;
    nxt_restart = 1'b0;
    nxt_iw_irq = 1'b0;
    // an error on the tick opens the new second's count instead of being lost
    if (crc4_err && sec_tick) begin
      nxt_crc_cnt = 10'h001;
    end else if (crc4_err && crc_cnt_ff != 10'h3FF) begin
      nxt_crc_cnt = crc_cnt_ff + 10'h001;
    end
    case (st_ff)
      e1ri_pkg::E1RI_ST_DOUBLE: begin
        nxt_tmr = 26'h000_0000;
        nxt_iw_rai = 1'b0;
        // basic alignment reached: look for the crc4 multiframe
        if (!loss_of_frame_flag && receive_framing_select[1]) begin
          nxt_st = e1ri_pkg::E1RI_ST_MF_SEARCH;
        end
      end
      e1ri_pkg::E1RI_ST_MF_SEARCH: begin
        nxt_tmr = tmr_ff + 26'h000_0001;
        if (loss_of_frame_flag || !receive_framing_select[1]) begin
          nxt_st = e1ri_pkg::E1RI_ST_DOUBLE;
        end else if (mf_found) begin
          nxt_st = e1ri_pkg::E1RI_ST_MF_SYNC;
          nxt_iw_rai = 1'b0;
        end else if (receive_framing_select == `E1RI_RFS_IWORK) begin
          if (tmr_ff == 26'(IWORK_CYC - 1)) begin
            nxt_iw_irq = 1'b1;
            if (extended_interworking) begin
              // keep searching with the alarm raised, no 8 ms resync
              nxt_iw_rai = 1'b1;
              nxt_tmr = 26'h000_0000;
            end else begin
              nxt_st = e1ri_pkg::E1RI_ST_IW_HOLD;
            end
          end
        end else if (auto_resync_enable && tmr_ff == 26'(RESYNC_CYC - 1)) begin
          nxt_restart = 1'b1;
          nxt_st = e1ri_pkg::E1RI_ST_DOUBLE;
        end else if (tmr_ff == 26'(RESYNC_CYC - 1)) begin
          nxt_tmr = 26'h000_0000;
        end
      end
      e1ri_pkg::E1RI_ST_MF_SYNC: begin
        nxt_tmr = 26'h000_0000;
        if (loss_of_frame_flag || !receive_framing_select[1]) begin
          nxt_st = e1ri_pkg::E1RI_ST_DOUBLE;
        end
      end
      e1ri_pkg::E1RI_ST_IW_HOLD: begin
        // stays in doubleframe format until alignment or mode changes
        nxt_tmr = 26'h000_0000;
        if (loss_of_frame_flag || receive_framing_select != `E1RI_RFS_IWORK) begin
          nxt_st = e1ri_pkg::E1RI_ST_DOUBLE;
        end
      end
      default: begin
        nxt_st = e1ri_pkg::E1RI_ST_DOUBLE;
      end
    endcase
    // too many crc4 errors in one second forces a full realignment
    if (auto_multiframe_resync && crc_cnt_ff > 10'(`E1RI_CRC_ERR_LIMIT)) begin
      nxt_restart = 1'b1;
      nxt_st = e1ri_pkg::E1RI_ST_DOUBLE;
      nxt_crc_cnt = 10'h000;
    end
  end

  always_ff @(posedge mclk) begin
    if (rx_rst) begin
      st_ff <= e1ri_pkg::E1RI_ST_DOUBLE;
      tmr_ff <= 26'h000_0000;
      sec_ff <= 26'h000_0000;
      crc_cnt_ff <= 10'h000;
      iw_rai_ff <= 1'b0;
      restart_search_ff <= 1'b0;
      iw_timeout_irq_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
      sec_ff <= nxt_sec;
      crc_cnt_ff <= nxt_crc_cnt;
      iw_rai_ff <= nxt_iw_rai;
      restart_search_ff <= nxt_restart;
      iw_timeout_irq_ff <= nxt_iw_irq;
    end
  end

  // transmit spare bits: e-bits and remote alarm
  logic [1:0] smf_err_ff, nxt_smf_err;
  logic [1:0] ebit_hold_ff, nxt_ebit_hold;
  logic [1:0] nxt_ebit;
  logic nxt_rai;

  always_comb begin
    nxt_smf_err = smf_err_ff | {smf1_crc_err, smf2_crc_err};
    nxt_ebit_hold = ebit_hold_ff;
    // latch at multiframe start so errors land in the next multiframe
    if (mf_start) begin
      nxt_ebit_hold = ~smf_err_ff;
      nxt_smf_err = {smf1_crc_err, smf2_crc_err};
    end
    if (loss_of_frame_flag) begin
      nxt_ebit = {ebit_polarity_control, ebit_polarity_control};
    end else if (auto_ebit_send) begin
      nxt_ebit = ebit_hold_ff;
    end else begin
      nxt_ebit = xmit_spare_ff[`E1RI_EBIT_HI:`E1RI_EBIT_LO];
    end
    nxt_rai = (auto_remote_alarm & loss_of_frame_flag) | iw_rai_ff;
  end

  always_ff @(posedge mclk) begin
    if (rst || transmitter_reset_ff) begin
      smf_err_ff <= 2'b00;
      ebit_hold_ff <= 2'b11;
      ebit_tx_ff <= 2'b00;
      rai_tx_ff <= 1'b0;
    end else begin
      smf_err_ff <= nxt_smf_err;
      ebit_hold_ff <= nxt_ebit_hold;
      ebit_tx_ff <= nxt_ebit;
      rai_tx_ff <= nxt_rai;
    end
  end

  assign sync_state_ff = st_ff;

endmodule

/* File: e1ri_host.sv */
// e1ri_host.sv: host model that programs the channel through load strobes.
// assumes the bench clock; strobes change 2 ns after a rising edge.
`timescale 1ns/10ps
module e1ri_host (
  input wire logic mclk,
  output logic [7:0] cfg_data,
  output logic [10:0] load_vec,
  output logic write_cmd
);
  initial begin
    cfg_data = 8'h00;
    load_vec = 11'h000;
    write_cmd = 1'b0;
  end

  // idx 0..10 pick a config byte, 11 the command byte; no unused place exists to write
  task automatic put(input int idx, input logic [7:0] d);
    @(posedge mclk);
    #2;
    cfg_data = (idx == 1) ? {d[7:1], 1'b0} : d;
    if (idx == 11) begin
      write_cmd = 1'b1;
    end else begin
      load_vec[idx] = 1'b1;
    end
    @(posedge mclk);
    #2;
    load_vec = 11'h000;
    write_cmd = 1'b0;
    // released data bus shows the inverse so a stale byte is never mistaken for a load
    cfg_data = ~cfg_data;
  endtask
endmodule

/* File: e1ri_channel_chk.sv */
// e1ri_channel_chk.sv: concurrent checks on the ports of the e1 channel block.
// assumes one mclk domain and a synchronous active-high reset.
`timescale 1ns/10ps
module e1ri_channel_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] cfg_data,
  input wire logic write_command_register,
  input wire logic rx_bit_en,
  input wire logic rx_bit,
  input wire logic loss_of_frame_flag,
  input wire logic out_enable_ff,
  input wire logic [7:0] framer_mode_2_ff,
  input wire logic [7:0] framer_mode_3_ff,
  input wire logic [7:0] xmit_spare_ff,
  input wire logic [7:0] los_detect_count_ff,
  input wire logic los_ff,
  input wire logic [1:0] sync_state_ff,
  input wire logic [1:0] ebit_tx_ff,
  input wire logic rai_tx_ff,
  input wire logic restart_search_ff,
  input wire logic iw_timeout_irq_ff,
  input wire logic transmitter_reset_ff,
  input wire logic receiver_reset_ff
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // run of zeros since the last one; cleared with the receive side
  logic [15:0] zrun_ff, nxt_zrun;
  always_comb begin
    nxt_zrun = zrun_ff;
    if (rx_bit_en) begin
      nxt_zrun = rx_bit ? 16'h0000 : zrun_ff + 16'h0001;
    end
  end
  always_ff @(posedge mclk) begin
    zrun_ff <= (reset || receiver_reset_ff) ? 16'h0000 : nxt_zrun;
  end

  a_reset_outputs_off: assert property (disable iff (1'b0)
    reset |=> !out_enable_ff && !los_ff && sync_state_ff == 2'b00 && !rai_tx_ff)
    else $error("outputs active in reset");
  a_release_hold: assert property ($fell(reset) |-> !out_enable_ff [*3] ##1 out_enable_ff)
    else $error("release not two edges late");
  a_cmd_pulse: assert property (
    write_command_register && !$past(reset) && !$past(reset, 2) |=>
    transmitter_reset_ff == $past(cfg_data[4]) && receiver_reset_ff == $past(cfg_data[6]))
    else $error("command pulses wrong");
  a_rx_reset_clear: assert property (receiver_reset_ff |=> !los_ff && sync_state_ff == 2'b00)
    else $error("receiver reset left state");
  a_ebit_async: assert property (loss_of_frame_flag && !transmitter_reset_ff |=>
    ebit_tx_ff == {2{$past(xmit_spare_ff[4])}})
    else $error("ebit not polarity value");
  a_rai_auto: assert property (
    framer_mode_2_ff[4] && loss_of_frame_flag && !transmitter_reset_ff |=> rai_tx_ff)
    else $error("rai missing");
  a_lof_double: assert property (loss_of_frame_flag |=> sync_state_ff == 2'b00)
    else $error("not doubleframe");
  a_restart_pulse: assert property (
    restart_search_ff |-> sync_state_ff == 2'b00 ##1 !restart_search_ff)
    else $error("restart pulse wrong");
  a_iw_hold: assert property (iw_timeout_irq_ff |->
    ##[0:1] sync_state_ff == (framer_mode_3_ff[0] ? 2'b01 : 2'b11))
    else $error("interworking state wrong");
  a_los_threshold: assert property ($rose(los_ff) |->
    zrun_ff == ({8'h00, los_detect_count_ff} + 16'h0001) * 16'h0010)
    else $error("los set at wrong count");
endmodule

bind e1ri_channel e1ri_channel_chk e1ri_channel_chk_inst (.mclk, .reset, .cfg_data,
  .write_command_register, .rx_bit_en, .rx_bit, .loss_of_frame_flag, .out_enable_ff,
  .framer_mode_2_ff, .framer_mode_3_ff, .xmit_spare_ff, .los_detect_count_ff, .los_ff,
  .sync_state_ff, .ebit_tx_ff, .rai_tx_ff, .restart_search_ff, .iw_timeout_irq_ff,
  .transmitter_reset_ff, .receiver_reset_ff);

/* File: e1ri_channel_tb_top.sv */
// e1ri_channel_tb_top.sv: self-checking bench for the e1 channel reset/init block.
// assumes the host model and checker files are compiled before it.
`timescale 1ns/10ps
module e1ri_channel_tb_top;
  // shortened timer counts keep the run small
  localparam int RSY = 40;
  localparam int IWK = 200;
  localparam int SEC = 2000;
  localparam logic [7:0] RST [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'h00, 8'h00, 8'hFD, 8'hFF};
  logic mclk, reset, rx_bit_en, rx_bit, lof, mf_found, mf_start, smf1, smf2, crc_err;
  logic wcmd, out_en, los, rai, rs_p, iw_p, xr, rr;
  logic [7:0] cfg_data;
  logic [10:0] ld;
  logic [1:0] st, eb;
  e1ri_pkg::e1ri_byte_t cur [13];
  logic [7:0] cmds [3] = '{8'h10, 8'h40, 8'h50};
  int miscompares, cmp_count, rs_cnt, iw_cnt;

  e1ri_host e1ri_host_inst (.mclk(mclk), .cfg_data(cfg_data), .load_vec(ld), .write_cmd(wcmd));
  e1ri_channel #(.RESYNC_CYC(RSY), .IWORK_CYC(IWK), .SECOND_CYC(SEC)) e1ri_channel_inst (
    .mclk(mclk), .reset(reset), .cfg_data(cfg_data), .load_framer_mode_0(ld[0]),
    .load_framer_mode_1(ld[1]), .load_framer_mode_2(ld[2]), .load_framer_mode_3(ld[3]),
    .load_xmit_spare(ld[4]), .load_system_interface_control(ld[5]),
    .load_global_configuration(ld[6]), .load_mode(ld[7]), .load_interrupt_mask_regs(ld[8]),
    .load_los_detect_count(ld[9]), .load_los_recovery_count(ld[10]),
    .write_command_register(wcmd), .rx_bit_en(rx_bit_en), .rx_bit(rx_bit),
    .loss_of_frame_flag(lof), .mf_found(mf_found), .mf_start(mf_start),
    .smf1_crc_err(smf1), .smf2_crc_err(smf2), .crc4_err(crc_err), .out_enable_ff(out_en),
    .framer_mode_0_ff(cur[0]), .framer_mode_1_ff(cur[1]), .framer_mode_2_ff(cur[2]),
    .framer_mode_3_ff(cur[3]), .xmit_spare_ff(cur[4]), .system_interface_control_ff(cur[5]),
    .global_configuration_ff(cur[6]), .mode_ff(cur[7]), .interrupt_mask_regs_ff(cur[8]),
    .los_detect_count_ff(cur[9]), .los_recovery_count_ff(cur[10]),
    .receive_addr_high_compare_ff(cur[11]), .receive_addr_low_compare_ff(cur[12]),
    .los_ff(los), .sync_state_ff(st), .ebit_tx_ff(eb), .rai_tx_ff(rai),
    .restart_search_ff(rs_p), .iw_timeout_irq_ff(iw_p), .transmitter_reset_ff(xr),
    .receiver_reset_ff(rr));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (rs_p === 1'b1) rs_cnt++;
    if (iw_p === 1'b1) iw_cnt++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic pulse(ref logic s);
    @(posedge mclk);
    #2;
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  task automatic bits(input int n, input logic v);
    // the idle inverse goes out a clock before the next bit, never in the same step
    repeat (n) begin
      @(posedge mclk);
      #2;
      rx_bit = v;
      rx_bit_en = 1'b1;
      cyc(1);
      rx_bit_en = 1'b0;
      rx_bit = ~v;
    end
  endtask

  task automatic do_reset(input int n);
    @(posedge mclk);
    #2;
    reset = 1'b1;
    cyc(n);
    chk(out_en, 1'b0);
    for (int i = 0; i < 13; i++) begin
      chk(cur[i], RST[i]);
    end
    chk(st, 2'b00);
    reset = 1'b0;
    cyc(2);
    chk(out_en, 1'b0);
    cyc(1);
    chk(out_en, 1'b1);
  endtask

  task automatic stop_test;
    $display("counts: %0d compares, %0d miscompares", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #300000;
    miscompares++;
    stop_test();
  end

  initial begin
    reset = 1'b1;
    {rx_bit_en, rx_bit, mf_found, mf_start, smf1, smf2, crc_err} = 7'h00;
    lof = 1'b1;
    {miscompares, cmp_count, rs_cnt, iw_cnt} = '0;
    do_reset(20);
    for (int i = 0; i < 11; i++) begin
      e1ri_host_inst.put(i, 8'h96 ^ (8'(i) << 4));
    end
    for (int i = 0; i < 11; i++) begin
      chk(cur[i], 8'h96 ^ (8'(i) << 4));
    end
    do_reset(400);
    $display("test reset and load done");
    // loss-of-signal thresholds are part of the basic set-up, before line traffic
    e1ri_host_inst.put(9, 8'h0A);
    e1ri_host_inst.put(10, 8'h15);
    bits(175, 1'b0);
    chk(los, 1'b0);
    bits(1, 1'b0);
    chk(los, 1'b1);
    bits(21, 1'b1);
    chk(los, 1'b1);
    bits(1, 1'b1);
    chk(los, 1'b0);
    bits(176, 1'b0);
    for (int i = 0; i < 3; i++) begin
      e1ri_host_inst.put(11, cmds[i]);
      chk({xr, rr}, {cmds[i][4], cmds[i][6]});
      cyc(1);
      chk({xr, rr}, 2'b00);
    end
    chk(los, 1'b0);
    chk(cur[9], 8'h0A);
    $display("test los and commands done");
    e1ri_host_inst.put(2, 8'h10);
    for (int e = 0; e < 2; e++) begin
      e1ri_host_inst.put(4, 8'(e) << 4);
      cyc(1);
      chk(eb, {2{e[0]}});
      chk(rai, 1'b1);
    end
    lof = 1'b0;
    cyc(2);
    chk(rai, 1'b0);
    e1ri_host_inst.put(4, 8'h08);
    pulse(mf_start);
    pulse(smf1);
    pulse(mf_start);
    cyc(1);
    chk(eb, 2'b01);
    pulse(smf2);
    pulse(mf_start);
    cyc(1);
    chk(eb, 2'b10);
    pulse(mf_start);
    cyc(1);
    chk(eb, 2'b11);
    $display("test ebit and alarm done");
    lof = 1'b1;
    e1ri_host_inst.put(1, 8'h02);
    e1ri_host_inst.put(2, 8'h80);
    rs_cnt = 0;
    lof = 1'b0;
    cyc(2);
    chk(st, 2'b01);
    cyc(RSY - 6);
    chk(8'(rs_cnt), 8'h00);
    cyc(8);
    chk(8'(rs_cnt), 8'h01);
    pulse(mf_found);
    cyc(1);
    chk(st, 2'b10);
    lof = 1'b1;
    e1ri_host_inst.put(1, 8'h00);
    e1ri_host_inst.put(2, 8'hC0);
    for (int x = 0; x < 2; x++) begin
      lof = 1'b1;
      e1ri_host_inst.put(3, 8'(x));
      iw_cnt = 0;
      lof = 1'b0;
      cyc(IWK - 4);
      chk(8'(iw_cnt), 8'h00);
      cyc(8);
      chk(8'(iw_cnt), 8'h01);
      chk(st, x ? 2'b01 : 2'b11);
      chk(rai, x[0]);
    end
    pulse(mf_found);
    cyc(2);
    chk(rai, 1'b0);
    $display("test framing timeouts done");
    lof = 1'b1;
    e1ri_host_inst.put(3, 8'h00);
    e1ri_host_inst.put(2, 8'hA0);
    e1ri_host_inst.put(11, 8'h40);
    // the receiver reset clears the error count one edge later; start counting after it
    cyc(1);
    lof = 1'b0;
    rs_cnt = 0;
    crc_err = 1'b1;
    cyc(914);
    crc_err = 1'b0;
    cyc(2);
    chk(8'(rs_cnt), 8'h00);
    pulse(crc_err);
    cyc(2);
    chk(8'(rs_cnt), 8'h01);
    $display("test crc error limit done");
    stop_test();
  end
endmodule
